// >>> tkc_pkg.sv
package tkc_pkg;
  localparam logic [7:0] OFF_FUNC_HIGH = 8'h00;
  localparam logic [7:0] OFF_FUNC_LOW = 8'h04;
  localparam logic [7:0] OFF_CF_HIGH = 8'h08;
  localparam logic [7:0] OFF_CF_LOW = 8'h0C;
  localparam logic [7:0] OFF_REF_HIGH = 8'h10;
  localparam logic [7:0] OFF_REF_LOW = 8'h14;
  localparam logic [7:0] OFF_OSC_CTL = 8'h18;
  localparam logic [7:0] OFF_SCAN_CTL = 8'h1C;
  localparam logic [7:0] OFF_KEY_CAP0 = 8'h20;
  localparam logic [7:0] OFF_KEY_CAP1 = 8'h24;
  localparam logic [7:0] OFF_KEY_CNT0 = 8'h28;
  localparam logic [7:0] OFF_KEY_CNT1 = 8'h2C;
  localparam int BIT_DOUBLE = 5;
  localparam int BIT_HOP_CTL = 3;
  localparam int BIT_START = 0;
  localparam int BIT_MODE_LO = 1;
  localparam int BIT_BUSY = 3;
  localparam logic [7:0] OSC_CTL_MASK = 8'h2F;
  localparam logic [15:0] COUNT_RESET = 16'h0000;
  localparam logic [9:0] REF_CAP_RESET = 10'h000;
  localparam logic [7:0] OSC_CTL_RESET = 8'h00;
  localparam logic [1:0] MODE_AUTO = 2'h0;
  localparam logic [1:0] MODE_MANUAL = 2'h1;
  localparam int CAP_FULL_PF = 30;
  localparam int CAP_STEPS = 1024;
  // hop codes 000..111 select 1.020,1.040,1.059,1.074,1.085,1.099,1.111,1.125 MHz
  localparam logic [2:0] HOP_CODE_1020K = 3'h0;
endpackage

// >>> tkc_pulse_sync.sv
`timescale 1ns/1ns
`default_nettype none
module tkc_pulse_sync (
  input wire logic ref_clk,
  input wire logic rst_n,
  input wire logic clk_en,
  input wire logic async_in,
  output logic rise
);
  logic stage1;
  logic stage2;
  logic stage3;
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      stage1 <= 1'b0;
      stage2 <= 1'b0;
      stage3 <= 1'b0;
    end else if (clk_en) begin
      stage1 <= async_in;
      stage2 <= stage1;
      stage3 <= stage2;
    end
  end
  assign rise = stage2 & ~stage3;
endmodule // tkc_pulse_sync
`default_nettype wire

// >>> tkc_counter_osc.sv
// Our own choices: the placing of the registers and the APB register port.
`timescale 1ns/1ns
`default_nettype none
// Summary of operation
// - two read-only 16-bit counters, reset zero
// - manual mode: slot overflow halts function counter
// - auto modes: function counter zeroed after slot 0
// - start bit cleared zeroes both counters
// - manual mode: slot overflow stops C/F counter
// - auto modes: copy C/F count, zero after slot0
// - auto modes: slot end loads next key's reference capacitor
// - 10-bit reference capacitor, value*30pF/1024
// - doubling bit doubles key oscillator frequency
// - hop select 1 uses hardware hopping
// - hop field picks one of eight frequencies
// - unimplemented control bits read zero
// - start bit rising edge starts counters, oscillators
// - mode 00 auto, 01 manual, 1x runs as auto
module tkc_counter_osc (
  input wire logic ref_clk,
  input wire logic rst_n,
  input wire logic clk_en,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic func_tick,
  input wire logic key_osc_in,
  input wire logic slot_end,
  input wire logic slot_index,
  input wire logic slot_overflow,
  input wire logic scan_done,
  output logic osc_enable,
  output logic freq_double,
  output logic hop_hw,
  output logic [2:0] hop_code,
  output logic [9:0] ref_cap
);
  import tkc_pkg::*;

  typedef enum logic [1:0] {
    ST_IDLE = 2'b01,
    ST_RUN = 2'b10
  } tkc_state_t;

  tkc_state_t state;
  logic [15:0] funcCount;
  logic [15:0] cfCount;
  logic [9:0] refCap;
  logic [7:0] oscCtl;
  logic startBit;
  logic [1:0] scanMode;
  logic busy;
  logic [9:0] keyCap [0:1];
  logic [15:0] keyCount [0:1];
  logic keyEdge;
  logic funcSync1;
  logic funcSync2;
  logic slotEndSync1;
  logic slotEndSync2;
  logic slotIdxSync1;
  logic slotIdxSync2;
  logic ovfSync1;
  logic ovfSync2;
  logic doneSync1;
  logic doneSync2;

  function automatic logic is_auto(input logic [1:0] m);
    return m != MODE_MANUAL;
  endfunction

  function automatic logic [15:0] inc16(input logic [15:0] v);
    return 16'(v + 16'h0001);
  endfunction

  tkc_pulse_sync keySync (
    .ref_clk(ref_clk),
    .rst_n(rst_n),
    .clk_en(clk_en),
    .async_in(key_osc_in),
    .rise(keyEdge)
  );

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      funcSync1 <= 1'b0;
      funcSync2 <= 1'b0;
      slotEndSync1 <= 1'b0;
      slotEndSync2 <= 1'b0;
      slotIdxSync1 <= 1'b0;
      slotIdxSync2 <= 1'b0;
      ovfSync1 <= 1'b0;
      ovfSync2 <= 1'b0;
      doneSync1 <= 1'b0;
      doneSync2 <= 1'b0;
    end else if (clk_en) begin
      funcSync1 <= func_tick;
      funcSync2 <= funcSync1;
      slotEndSync1 <= slot_end;
      slotEndSync2 <= slotEndSync1;
      slotIdxSync1 <= slot_index;
      slotIdxSync2 <= slotIdxSync1;
      ovfSync1 <= slot_overflow;
      ovfSync2 <= ovfSync1;
      doneSync1 <= scan_done;
      doneSync2 <= doneSync1;
    end
  end

  // slot_end is a level per slot boundary; act once on its rising edge
  logic slotEndPrev;
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      slotEndPrev <= 1'b0;
    end else if (clk_en) begin
      slotEndPrev <= slotEndSync2;
    end
  end

  wire access = psel & penable;
  wire wrEn = access & pwrite;
  wire hitFuncH = paddr == OFF_FUNC_HIGH;
  wire hitFuncL = paddr == OFF_FUNC_LOW;
  wire hitCfH = paddr == OFF_CF_HIGH;
  wire hitCfL = paddr == OFF_CF_LOW;
  wire hitRefH = paddr == OFF_REF_HIGH;
  wire hitRefL = paddr == OFF_REF_LOW;
  wire hitOsc = paddr == OFF_OSC_CTL;
  wire hitScan = paddr == OFF_SCAN_CTL;
  wire hitCap0 = paddr == OFF_KEY_CAP0;
  wire hitCap1 = paddr == OFF_KEY_CAP1;
  wire hitCnt0 = paddr == OFF_KEY_CNT0;
  wire hitCnt1 = paddr == OFF_KEY_CNT1;
  wire mapped = hitFuncH | hitFuncL | hitCfH | hitCfL | hitRefH | hitRefL | hitOsc
    | hitScan | hitCap0 | hitCap1 | hitCnt0 | hitCnt1;
  // read-only registers refuse writes with an error
  wire roHit = hitFuncH | hitFuncL | hitCfH | hitCfL | hitCnt0 | hitCnt1;
  wire badAccess = ~mapped | (pwrite & roHit);

  wire scanWr = wrEn & hitScan;
  wire next_startBit = pwdata[BIT_START];
  wire startRise = scanWr & next_startBit & ~startBit;
  wire stopWr = scanWr & ~next_startBit;
  wire running = state == ST_RUN;
  wire slotEndPulse = slotEndSync2 & ~slotEndPrev;
  wire slotEndAuto = running & slotEndPulse & is_auto(scanMode);
  wire slot0End = slotEndAuto & ~slotIdxSync2;
  // slot 1 end keeps the counter but still records key 1's result
  wire slot1End = slotEndAuto & slotIdxSync2;
  wire manualStop = running & ovfSync2 & (scanMode == MODE_MANUAL);
  wire autoStop = running & doneSync2 & is_auto(scanMode);
  wire nextSlot = ~slotIdxSync2;

  logic [31:0] next_prdata;
  always_comb begin
    next_prdata = 32'h0000_0000;
    if (hitFuncH) begin
      next_prdata = {24'h00_0000, funcCount[15:8]};
    end else if (hitFuncL) begin
      next_prdata = {24'h00_0000, funcCount[7:0]};
    end else if (hitCfH) begin
      next_prdata = {24'h00_0000, cfCount[15:8]};
    end else if (hitCfL) begin
      next_prdata = {24'h00_0000, cfCount[7:0]};
    end else if (hitRefH) begin
      next_prdata = {30'h0000_0000, refCap[9:8]};
    end else if (hitRefL) begin
      next_prdata = {24'h00_0000, refCap[7:0]};
    end else if (hitOsc) begin
      next_prdata = {24'h00_0000, oscCtl & OSC_CTL_MASK};
    end else if (hitScan) begin
      next_prdata = {28'h000_0000, busy, scanMode, startBit};
    end else if (hitCap0) begin
      next_prdata = {22'h00_0000, keyCap[0]};
    end else if (hitCap1) begin
      next_prdata = {22'h00_0000, keyCap[1]};
    end else if (hitCnt0) begin
      next_prdata = {16'h0000, keyCount[0]};
    end else if (hitCnt1) begin
      next_prdata = {16'h0000, keyCount[1]};
    end
  end

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      prdata <= 32'h0000_0000;
      pready <= 1'b0;
      pslverr <= 1'b0;
    end else if (clk_en) begin
      pready <= psel & ~penable;
      pslverr <= psel & ~penable & badAccess;
      prdata <= next_prdata;
    end
  end

  // apb access completes when pready is high at the first edge of access
  wire wrCommit = wrEn & pready;
  wire startCommit = startRise & pready;
  wire stopCommit = stopWr & pready;

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      startBit <= 1'b0;
      scanMode <= MODE_AUTO;
      busy <= 1'b0;
      state <= ST_IDLE;
    end else if (clk_en) begin
      if (scanWr & pready) begin
        startBit <= next_startBit;
        scanMode <= pwdata[BIT_MODE_LO +: 2];
      end
      case (state)
        ST_IDLE: begin
          if (startCommit) begin
            state <= ST_RUN;
            busy <= 1'b1;
          end
        end
        ST_RUN: begin
          if (stopCommit | manualStop | autoStop) begin
            state <= ST_IDLE;
            busy <= 1'b0;
          end
        end
        default: state <= ST_IDLE;
      endcase
    end
  end

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      funcCount <= COUNT_RESET;
      cfCount <= COUNT_RESET;
    end else if (clk_en) begin
      if (stopCommit) begin
        funcCount <= COUNT_RESET;
        cfCount <= COUNT_RESET;
      end else if (slot0End) begin
        funcCount <= COUNT_RESET;
        cfCount <= COUNT_RESET;
      end else if (running & ~manualStop) begin
        if (funcSync2) begin
          funcCount <= inc16(funcCount);
        end
        if (keyEdge) begin
          cfCount <= inc16(cfCount);
        end
      end
    end
  end

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      keyCount[0] <= COUNT_RESET;
      keyCount[1] <= COUNT_RESET;
    end else if (clk_en) begin
      if (slot0End) begin
        keyCount[0] <= cfCount;
      end
      if (slot1End) begin
        keyCount[1] <= cfCount;
      end
    end
  end

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      refCap <= REF_CAP_RESET;
      oscCtl <= OSC_CTL_RESET;
      keyCap[0] <= REF_CAP_RESET;
      keyCap[1] <= REF_CAP_RESET;
    end else if (clk_en) begin
      if (slotEndAuto) begin
        refCap <= keyCap[nextSlot];
      end else if (wrCommit & hitRefH) begin
        refCap[9:8] <= pwdata[1:0];
      end else if (wrCommit & hitRefL) begin
        refCap[7:0] <= pwdata[7:0];
      end
      if (wrCommit & hitOsc) begin
        oscCtl <= pwdata[7:0] & OSC_CTL_MASK;
      end
      if (wrCommit & hitCap0) begin
        keyCap[0] <= pwdata[9:0];
      end
      if (wrCommit & hitCap1) begin
        keyCap[1] <= pwdata[9:0];
      end
    end
  end

  // outputs to the analog oscillator block, all registered
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      osc_enable <= 1'b0;
      freq_double <= 1'b0;
      hop_hw <= 1'b0;
      hop_code <= HOP_CODE_1020K;
      ref_cap <= REF_CAP_RESET;
    end else if (clk_en) begin
      osc_enable <= running;
      freq_double <= oscCtl[BIT_DOUBLE];
      hop_hw <= oscCtl[BIT_HOP_CTL];
      hop_code <= oscCtl[BIT_HOP_CTL] ? HOP_CODE_1020K : oscCtl[2:0];
      ref_cap <= refCap;
    end
  end
endmodule // tkc_counter_osc
`default_nettype wire

// >>> tkc_assertions.sv
`timescale 1ns/1ns
`default_nettype none
module tkc_checker
  import tkc_pkg::*;
(
  input wire logic ref_clk,
  input wire logic rst_n,
  input wire logic clk_en,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  input wire logic osc_enable,
  input wire logic freq_double,
  input wire logic hop_hw,
  input wire logic [2:0] hop_code,
  input wire logic [9:0] ref_cap
);
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!rst_n);
  wire wrDone = psel && penable && pready && pwrite;
  wire rdDone = psel && penable && pready && !pwrite;
  AST_PREADY_PULSE: assert property (pready && clk_en |=> !pready) else $error("pready too long");
  AST_SETUP_ANSWER: assert property (psel && !penable && clk_en |=> pready) else $error("no answer");
  AST_RO_REFUSED: assert property (wrDone && paddr <= OFF_CF_LOW |-> pslverr)
    else $error("ro write taken");
  AST_CTL_READ_ZERO: assert property (rdDone && paddr == OFF_OSC_CTL |->
    (prdata & ~{24'h00_0000, OSC_CTL_MASK}) == 32'h0000_0000) else $error("ctl bits");
  AST_REF_HIGH_WRITE: assert property (wrDone && clk_en && paddr == OFF_REF_HIGH
    ##1 clk_en |=> ref_cap[9:8] == $past(pwdata[1:0], 2)) else $error("ref high");
  AST_REF_LOW_WRITE: assert property (wrDone && clk_en && paddr == OFF_REF_LOW
    ##1 clk_en |=> ref_cap[7:0] == $past(pwdata[7:0], 2)) else $error("ref low");
  AST_DOUBLE_WRITE: assert property (wrDone && clk_en && paddr == OFF_OSC_CTL
    ##1 clk_en |=> freq_double == $past(pwdata[BIT_DOUBLE], 2)) else $error("double");
  AST_HOP_HW_CODE: assert property (hop_hw |-> hop_code == 3'h0) else $error("hop code");
  AST_HOP_FIELD: assert property (wrDone && clk_en && paddr == OFF_OSC_CTL
    ##1 clk_en |=> hop_hw || hop_code == $past(pwdata[2:0], 2)) else $error("hop field");
  AST_START_OSC: assert property (wrDone && paddr == OFF_SCAN_CTL && pwdata[0] |->
    ##[1:4] osc_enable) else $error("no start");
  AST_STOP_OSC: assert property (wrDone && paddr == OFF_SCAN_CTL && !pwdata[0] |->
    ##[1:4] !osc_enable) else $error("no stop");
endmodule // tkc_checker
bind tkc_counter_osc tkc_checker chk (.ref_clk(ref_clk), .rst_n(rst_n), .clk_en(clk_en),
  .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
  .prdata(prdata), .pready(pready), .pslverr(pslverr), .osc_enable(osc_enable),
  .freq_double(freq_double), .hop_hw(hop_hw), .hop_code(hop_code), .ref_cap(ref_cap));
`default_nettype wire

// >>> tkc_pads_model.sv
`timescale 1ns/1ns
`default_nettype none
module tkc_pads_model (
  input wire logic oscOn,
  input wire logic touch,
  input wire logic dbl,
  output logic keyOsc,
  output logic funcTick
);
  // pad period unrelated to ref_clk; pad stays still when off
  initial begin
    keyOsc = 1'b0;
    forever begin
      #(dbl ? 23 : 47);
      if (oscOn && touch) keyOsc = ~keyOsc;
    end
  end
  assign funcTick = oscOn & touch;
endmodule // tkc_pads_model
`default_nettype wire

// >>> tkc_tb.sv
`timescale 1ns/1ns
`default_nettype none
module tb;
  import tkc_pkg::*;
  logic ref_clk = 1'b0, rst_n = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic slotEnd = 1'b0, slotIdx = 1'b0, slotOvf = 1'b0, scanDone = 1'b0, touch = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0000_0000, prdata, rv, v, cf, fn;
  logic [31:0] ex = 32'h0000_0000;
  logic clkEn = 1'b1;
  logic pready, pslverr, oscEn, dbl, hopHw, keyOsc, funcTick;
  logic [2:0] hopCode;
  logic [9:0] refCap, cap0, cap1;
  int fails = 0, checked = 0, seed = 2518;
  always #10 ref_clk = ~ref_clk;
  tkc_counter_osc dut (.ref_clk(ref_clk), .rst_n(rst_n), .clk_en(clkEn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .func_tick(funcTick), .key_osc_in(keyOsc),
    .slot_end(slotEnd), .slot_index(slotIdx), .slot_overflow(slotOvf), .scan_done(scanDone),
    .osc_enable(oscEn), .freq_double(dbl), .hop_hw(hopHw), .hop_code(hopCode), .ref_cap(refCap));
  tkc_pads_model pads (.oscOn(oscEn), .touch(touch), .dbl(dbl), .keyOsc(keyOsc),
    .funcTick(funcTick));
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    checked++;
    if (seen !== exp) begin
      fails++;
      $display("ERROR t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task automatic complete_run;
    if (fails == 0 && checked > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d, input logic err);
    int n;
    @(posedge ref_clk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge ref_clk);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge ref_clk);
      n++;
    end while (pready !== 1'b1 && n < 20);
    if (pready !== 1'b1) fails++;
    rv = prdata;
    check({31'h0, pslverr}, {31'h0, err});
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic pair(input logic [7:0] hi, output logic [31:0] val);
    apb(1'b0, hi, 32'h0, 1'b0);
    val = rv << 8;
    apb(1'b0, hi + 8'h04, 32'h0, 1'b0);
    val = val | rv;
  endtask
  task automatic idle;
    int n;
    n = 0;
    do begin
      apb(1'b0, OFF_SCAN_CTL, 32'h0, 1'b0);
      n++;
    end while (rv[BIT_BUSY] !== 1'b0 && n < 50);
    check({31'h0, rv[BIT_BUSY]}, 32'h0);
  endtask
  task automatic wait_clk(input int n);
    repeat (n) @(posedge ref_clk);
  endtask
  task automatic slot(input logic idx, input logic [9:0] expCap);
    pair(OFF_CF_HIGH, cf);
    pair(OFF_FUNC_HIGH, fn);
    slotIdx <= idx;
    slotEnd <= 1'b1;
    wait_clk(6);
    slotEnd <= 1'b0;
    check({22'h0, refCap}, {22'h0, expCap});
  endtask
  initial begin
    #1_000_000;
    fails++;
    complete_run;
  end
  initial begin
    wait_clk(2);
    rst_n <= 1'b1;
    for (int a = 0; a <= 24; a += 4) begin
      apb(1'b0, 8'(a), 32'h0, 1'b0);
      check(rv, 32'h0);
    end
    apb(1'b1, OFF_FUNC_HIGH, 32'h0000_00FF, 1'b1);
    apb(1'b0, 8'h30, 32'h0, 1'b1);
    for (int i = 0; i < 16; i++) begin
      v = $random(seed);
      v[3:0] = 4'(i);
      apb(1'b1, OFF_OSC_CTL, v, 1'b0);
      if (i == 8) begin
        clkEn <= 1'b0;
        wait_clk(3);
        check({27'h0, hopHw, dbl, hopCode}, ex);
        clkEn <= 1'b1;
      end
      wait_clk(2);
      ex = {27'h0, v[3], v[5], v[3] ? 3'h0 : v[2:0]};
      check({27'h0, hopHw, dbl, hopCode}, ex);
      apb(1'b0, OFF_OSC_CTL, 32'h0, 1'b0);
      check(rv, v & 32'h0000_002F);
      v = (i == 0) ? 32'hFFFF_FFFF : $random(seed);
      apb(1'b1, OFF_REF_HIGH, v, 1'b0);
      apb(1'b1, OFF_REF_LOW, v >> 8, 1'b0);
      wait_clk(2);
      check({22'h0, refCap}, {22'h0, v[1:0], v[15:8]});
    end
    for (int m = 0; m < 4; m++) begin
      apb(1'b1, OFF_SCAN_CTL, 32'(m * 2 + 1), 1'b0);
      apb(1'b0, OFF_SCAN_CTL, 32'h0, 1'b0);
      check(rv & 32'h7, 32'(m * 2 + 1));
      apb(1'b1, OFF_SCAN_CTL, 32'h0, 1'b0);
    end
    touch <= 1'b1;
    apb(1'b1, OFF_SCAN_CTL, {29'h0, MODE_MANUAL, 1'b1}, 1'b0);
    wait_clk(60);
    slotOvf <= 1'b1;
    idle;
    pair(OFF_CF_HIGH, cf);
    pair(OFF_FUNC_HIGH, fn);
    check({31'h0, cf != 0 && fn != 0}, 32'h1);
    wait_clk(40);
    pair(OFF_CF_HIGH, v);
    check(v, cf);
    pair(OFF_FUNC_HIGH, v);
    check(v, fn);
    slotOvf <= 1'b0;
    apb(1'b1, OFF_SCAN_CTL, 32'h0, 1'b0);
    pair(OFF_CF_HIGH, v);
    pair(OFF_FUNC_HIGH, fn);
    check(v | fn, 32'h0);
    cap0 = 10'($random(seed));
    cap1 = 10'($random(seed));
    apb(1'b1, OFF_KEY_CAP0, {22'h0, cap0}, 1'b0);
    apb(1'b1, OFF_KEY_CAP1, {22'h0, cap1}, 1'b0);
    apb(1'b1, OFF_SCAN_CTL, 32'h1, 1'b0);
    wait_clk(60);
    touch <= 1'b0;
    wait_clk(10);
    slot(1'b0, cap1);
    apb(1'b0, OFF_KEY_CNT0, 32'h0, 1'b0);
    check(rv, cf);
    pair(OFF_CF_HIGH, v);
    pair(OFF_FUNC_HIGH, fn);
    check(v | fn, 32'h0);
    touch <= 1'b1;
    wait_clk(30);
    touch <= 1'b0;
    wait_clk(10);
    slot(1'b1, cap0);
    apb(1'b0, OFF_KEY_CNT1, 32'h0, 1'b0);
    check(rv, cf);
    pair(OFF_CF_HIGH, v);
    check(v, cf);
    pair(OFF_FUNC_HIGH, v);
    check(v, fn);
    scanDone <= 1'b1;
    idle;
    complete_run;
  end
endmodule // tb
`default_nettype wire
